// *** rtl/scs_config_slave.v ***
`timescale 1ns/10ps
`default_nettype none
`include "scs_defines.vh"

// Behaviour
// - Slave only; accepts writes, returns reads
// - Master reads and writes read/write registers
// - Read-only and preloaded registers also writable
// - Drives/releases clock and data, open drain
// - Address bits 2:0 from strap pins
// - Address bits 6:3 fixed 1101; match only
module scs_config_slave #(
   parameter OFFS_W = 8
) (
   input wire clk,
   input wire resetn,
   input wire mgmt_serial_clock_pin_i,
   output reg mgmt_serial_clock_pin_o,
   output reg mgmt_serial_clock_pin_oe,
   input wire mgmt_serial_data_pin_i,
   output reg mgmt_serial_data_pin_o,
   output reg mgmt_serial_data_pin_oe,
   input wire [2:0] addr_strap,
   output reg [OFFS_W-1:0] cfg_addr,
   output reg [7:0] cfg_wdata,
   output reg cfg_wr,
   output reg cfg_rd,
   input wire [7:0] cfg_rdata
);

   // Protocol states
   localparam ST_IDLE = 3'h0;
   localparam ST_RX = 3'h1;
   localparam ST_RX_ACK = 3'h2;
   localparam ST_FETCH = 3'h3;
   localparam ST_TX = 3'h4;
   localparam ST_TX_ACK = 3'h5;

   reg scl_s1_r; // First synchroniser stage, clock line
   reg scl_s2_r; // Second stage
   reg scl_d_r; // Delayed copy for edge detection
   reg sda_s1_r; // First synchroniser stage, data line
   reg sda_s2_r; // Second stage
   reg sda_d_r; // Delayed copy for edge detection
   reg [2:0] state_r; // Protocol state
   reg [1:0] kind_r; // Kind of byte being received
   reg [3:0] bitcnt_r; // Bits handled in current byte
   reg [7:0] shift_r; // Receive and transmit shift register
   reg rnw_r; // Direction bit of last matched address
   reg mack_r; // Master acknowledge sampled after a read byte
   reg fetch_r; // Second cycle of a register fetch
   reg [2:0] strap_r; // Synchronised strap levels
   reg [2:0] strap_s1_r; // First strap synchroniser stage

   wire scl_rise; // Clock line rising edge
   wire scl_fall; // Clock line falling edge
   wire start_ev; // Start or repeated start
   wire stop_ev; // Stop condition
   wire addr_hit; // Received address equals ours

   assign scl_rise = scl_s2_r & ~scl_d_r;
   assign scl_fall = ~scl_s2_r & scl_d_r;
   assign start_ev = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
   assign stop_ev = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;
   // Fixed upper bits with strapped low bits
   assign addr_hit = (shift_r[7:1] == {`SCS_ADDR_HI, strap_r});

   // Pin synchronisers and edge history
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r <= 1'b1;
         strap_s1_r <= 3'h0;
         strap_r <= 3'h0;
      end else begin
         scl_s1_r <= mgmt_serial_clock_pin_i;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sda_s1_r <= mgmt_serial_data_pin_i;
         sda_s2_r <= sda_s1_r;
         sda_d_r <= sda_s2_r;
         strap_s1_r <= addr_strap; // Straps sampled continuously
         strap_r <= strap_s1_r;
      end
   end

   // Slave protocol engine
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         kind_r <= `SCS_KIND_ADDR;
         bitcnt_r <= 4'h0;
         shift_r <= `SCS_BYTE_RST;
         rnw_r <= 1'b0;
         mack_r <= 1'b0;
         fetch_r <= 1'b0;
         cfg_addr <= {OFFS_W{1'b0}};
         cfg_wdata <= `SCS_BYTE_RST;
         cfg_wr <= 1'b0;
         cfg_rd <= 1'b0;
         mgmt_serial_clock_pin_o <= 1'b0;
         mgmt_serial_clock_pin_oe <= 1'b0;
         mgmt_serial_data_pin_o <= 1'b0;
         mgmt_serial_data_pin_oe <= 1'b0;
      end else begin
         // Strobes last one cycle
         cfg_wr <= 1'b0;
         cfg_rd <= 1'b0;
         if (start_ev) begin
            // Start: always expect an address byte, offset is kept
            state_r <= ST_RX;
            kind_r <= `SCS_KIND_ADDR;
            bitcnt_r <= 4'h0;
            mgmt_serial_data_pin_oe <= 1'b0;
            mgmt_serial_clock_pin_oe <= 1'b0;
         end else if (stop_ev) begin
            // Stop: release both lines
            state_r <= ST_IDLE;
            mgmt_serial_data_pin_oe <= 1'b0;
            mgmt_serial_clock_pin_oe <= 1'b0;
         end else begin
            case (state_r)
               ST_RX: begin
                  if (scl_rise) begin
                     // Sample data on clock rising edge
                     shift_r <= {shift_r[6:0], sda_s2_r};
                     bitcnt_r <= bitcnt_r + 4'h1;
                  end else if (scl_fall && bitcnt_r == `SCS_BYTE_BITS) begin
                     bitcnt_r <= 4'h0;
                     if (kind_r == `SCS_KIND_ADDR) begin
                        if (addr_hit) begin
                           // Acknowledge our address only
                           rnw_r <= shift_r[0];
                           mgmt_serial_data_pin_oe <= 1'b1;
                           state_r <= ST_RX_ACK;
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end else if (kind_r == `SCS_KIND_OFFS) begin
                        // Register offset selects the target
                        cfg_addr <= shift_r[OFFS_W-1:0];
                        mgmt_serial_data_pin_oe <= 1'b1;
                        state_r <= ST_RX_ACK;
                     end else begin
                        // Write any register type, read-only included
                        cfg_wdata <= shift_r;
                        cfg_wr <= 1'b1;
                        mgmt_serial_data_pin_oe <= 1'b1;
                        state_r <= ST_RX_ACK;
                     end
                  end
               end
               ST_RX_ACK: begin
                  if (scl_fall) begin
                     // End of acknowledge clock: release data
                     mgmt_serial_data_pin_oe <= 1'b0;
                     if (kind_r == `SCS_KIND_ADDR && rnw_r) begin
                        // Read: stretch the clock while fetching
                        mgmt_serial_clock_pin_oe <= 1'b1;
                        cfg_rd <= 1'b1;
                        fetch_r <= 1'b0;
                        state_r <= ST_FETCH;
                     end else begin
                        if (kind_r == `SCS_KIND_ADDR) begin
                           kind_r <= `SCS_KIND_OFFS;
                        end else if (kind_r == `SCS_KIND_OFFS) begin
                           kind_r <= `SCS_KIND_DATA;
                        end else begin
                           // Auto-increment after each written byte
                           cfg_addr <= cfg_addr + {{(OFFS_W-1){1'b0}}, 1'b1};
                        end
                        state_r <= ST_RX;
                     end
                  end
               end
               ST_FETCH: begin
                  // Data arrives the cycle after the read strobe
                  fetch_r <= 1'b1;
                  if (fetch_r) begin
                     shift_r <= cfg_rdata;
                     mgmt_serial_data_pin_oe <= ~cfg_rdata[7];
                     mgmt_serial_clock_pin_oe <= 1'b0;
                     cfg_addr <= cfg_addr + {{(OFFS_W-1){1'b0}}, 1'b1};
                     bitcnt_r <= 4'h0;
                     state_r <= ST_TX;
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bitcnt_r <= bitcnt_r + 4'h1;
                  end else if (scl_fall) begin
                     if (bitcnt_r == `SCS_BYTE_BITS) begin
                        // Free the line for the master acknowledge
                        mgmt_serial_data_pin_oe <= 1'b0;
                        state_r <= ST_TX_ACK;
                     end else begin
                        // Next bit, open drain: pull low for zero
                        shift_r <= {shift_r[6:0], 1'b0};
                        mgmt_serial_data_pin_oe <= ~shift_r[6];
                     end
                  end
               end
               ST_TX_ACK: begin
                  if (scl_rise) begin
                     mack_r <= ~sda_s2_r;
                  end else if (scl_fall) begin
                     if (mack_r) begin
                        // Master wants more: fetch the next byte
                        mgmt_serial_clock_pin_oe <= 1'b1;
                        cfg_rd <= 1'b1;
                        fetch_r <= 1'b0;
                        state_r <= ST_FETCH;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  // Idle: wait for a start
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// *** rtl/scs_defines.vh ***
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// Fixed upper slave address bits [6:3]
`define SCS_ADDR_HI 4'hd
// Bits per serial byte
`define SCS_BYTE_BITS 4'h8

// Byte kinds received after a start
`define SCS_KIND_ADDR 2'h0
`define SCS_KIND_OFFS 2'h1
`define SCS_KIND_DATA 2'h2

// Reset values
`define SCS_OFFS_RST 8'h00
`define SCS_BYTE_RST 8'h00

`endif

// *** tb/scs_config_slave_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module scs_chk #(parameter OFFS_W = 8) (
   input wire clk,
   input wire resetn,
   input wire mgmt_serial_clock_pin_o,
   input wire mgmt_serial_clock_pin_oe,
   input wire mgmt_serial_data_pin_o,
   input wire mgmt_serial_data_pin_oe,
   input wire [OFFS_W-1:0] cfg_addr,
   input wire cfg_wr,
   input wire cfg_rd
);
   reg [OFFS_W-1:0] last_r; // Offset of the latest access
   always @(posedge clk or negedge resetn) begin
      if (!resetn) last_r <= {OFFS_W{1'b0}};
      else if (cfg_wr | cfg_rd) last_r <= cfg_addr;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   open_drain_a: assert property (!mgmt_serial_clock_pin_o && !mgmt_serial_data_pin_o) else $error("pin high");
   one_op_a: assert property (!(cfg_wr && cfg_rd)) else $error("read with write");
   wr_pulse_a: assert property (cfg_wr |=> !cfg_wr) else $error("long write");
   wr_ack_a: assert property (cfg_wr |-> ##[0:1] mgmt_serial_data_pin_oe) else $error("no ack");
   rd_stretch_a: assert property (cfg_rd |-> mgmt_serial_clock_pin_oe [*2] ##1 !mgmt_serial_clock_pin_oe)
      else $error("bad stretch");
   wr_incr_a: assert property (cfg_wr |=> ##[0:20] cfg_addr == last_r + 1'b1) else $error("no incr");
   rd_incr_a: assert property (cfg_rd |=> ##[0:3] cfg_addr == last_r + 1'b1) else $error("no incr");
   cover property (cfg_wr);
   cover property (cfg_rd);
   cover property ($rose(mgmt_serial_clock_pin_oe));
endmodule
bind scs_config_slave scs_chk #(.OFFS_W(OFFS_W)) chk_i (.clk(clk), .resetn(resetn), .cfg_addr(cfg_addr),
   .mgmt_serial_clock_pin_o(mgmt_serial_clock_pin_o), .mgmt_serial_clock_pin_oe(mgmt_serial_clock_pin_oe),
   .mgmt_serial_data_pin_o(mgmt_serial_data_pin_o), .mgmt_serial_data_pin_oe(mgmt_serial_data_pin_oe),
   .cfg_wr(cfg_wr), .cfg_rd(cfg_rd));
`default_nettype wire

// *** tb/scs_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Bus master: idle lines high, clock still between frames
module scs_master_model (
   input wire logic clk,
   input wire logic scl_w,
   input wire logic sda_w,
   output var logic scl_m,
   output var logic sda_m
);
   int n_stall; // Bits whose clock was held low past the bound
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
      n_stall = 0;
   end
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Start or repeated start: data falls while clock high
   task start();
      wt(2); sda_m <= 1'b1; wt(3); scl_m <= 1'b1; wt(4); sda_m <= 1'b0; wt(4); scl_m <= 1'b0;
   endtask
   // Stop: data rises while clock high
   task stop();
      wt(2); sda_m <= 1'b0; wt(3); scl_m <= 1'b1; wt(4); sda_m <= 1'b1; wt(4);
   endtask
   // Nine bits MSB first, 6 clk low and 2 clk high (800 ns); slave may stretch the clock
   task xfer(input logic [8:0] tx, output logic [8:0] rx);
      int j;
      for (int i = 8; i >= 0; i--) begin
         wt(3);
         sda_m <= tx[i];
         wt(3);
         scl_m <= 1'b1;
         for (j = 0; j < 20 && scl_w !== 1'b1; j++) wt(1);
         if (j >= 20) n_stall++;
         rx[i] = sda_w;
         wt(1);
         scl_m <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** tb/test_smbus_config_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "scs_defines.vh"
module test_smbus_config_slave;
   logic clk, resetn;
   logic [2:0] strap;
   logic [7:0] cfg_rdata, off, d0, d1;
   logic [7:0] mem [0:255]; // Register file
   logic [6:0] a; // Expected slave address
   logic [8:0] rx;
   logic [15:0] q[$]; // Expected writes
   int failures, n_tests;
   wire [7:0] cfg_addr, cfg_wdata;
   wire cfg_wr, cfg_rd, scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe;
   wire scl_w = scl_m & (scl_o | ~scl_oe); // Pulled-up wires
   wire sda_w = sda_m & (sda_o | ~sda_oe);
   scs_config_slave DUT (.clk(clk), .resetn(resetn), .mgmt_serial_clock_pin_i(scl_w),
      .mgmt_serial_clock_pin_o(scl_o), .mgmt_serial_clock_pin_oe(scl_oe), .mgmt_serial_data_pin_i(sda_w),
      .mgmt_serial_data_pin_o(sda_o), .mgmt_serial_data_pin_oe(sda_oe), .addr_strap(strap), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata));
   scs_master_model mst (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input bit ok, input string m);
      n_tests++;
      if (!ok) begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task end_sim();
      if (failures == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Register file answers a read one cycle later
   always @(posedge clk) begin
      if (cfg_wr === 1'b1) mem[cfg_addr] <= cfg_wdata;
      if (resetn !== 1'b1) cfg_rdata <= 8'h00;
      else if (cfg_rd === 1'b1) cfg_rdata <= mem[cfg_addr];
   end
   // A clock held low past the model's bound ends the run
   always @(posedge clk) if (mst.n_stall != 0) begin
      chk(1'b0, "clock held");
      end_sim();
   end
   // Each write taken against the oldest note
   always @(posedge clk) if (cfg_wr === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "stray write");
      else chk({cfg_addr, cfg_wdata} === q.pop_front(), "write");
   end
   initial begin
      repeat (90000) @(posedge clk);
      chk(1'b0, "timeout");
      end_sim();
   end
   initial begin
      void'($urandom(32'h89ef7761));
      resetn = 1'b0; strap = 3'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         strap <= 3'($urandom); off <= 8'($urandom); d0 <= 8'($urandom); d1 <= 8'($urandom);
         repeat (5) @(posedge clk);
         a = {`SCS_ADDR_HI, strap};
         q.push_back({off, d0});
         q.push_back({off + 8'h01, d1});
         mst.start(); mst.xfer({a, 2'b01}, rx); chk(rx[0] === 1'b0, "addr");
         mst.xfer({off, 1'b1}, rx); chk(rx[0] === 1'b0, "offset");
         mst.xfer({d0, 1'b1}, rx); chk(rx[0] === 1'b0, "data");
         mst.xfer({d1, 1'b1}, rx); chk(rx[0] === 1'b0, "data");
         mst.stop(); mst.start(); mst.xfer({a, 2'b01}, rx); mst.xfer({off, 1'b1}, rx);
         mst.start(); mst.xfer({a, 2'b11}, rx); chk(rx[0] === 1'b0, "read addr");
         mst.xfer(9'h1fe, rx); chk(rx[8:1] === d0, "read 0");
         mst.xfer(9'h1ff, rx); chk(rx[8:1] === d1, "read 1");
         mst.stop();
         for (int b = 0; b < 7; b++) begin
            mst.start(); mst.xfer({a ^ 7'(1 << b), 2'b01}, rx); chk(rx[0] === 1'b1, "wrong addr");
            mst.stop();
         end
      end
      chk(q.size() == 0, "lost write");
      end_sim();
   end
endmodule
`default_nettype wire
